// File: rtl/gpio_port_data.sv
// data registers of ports j, k, l and the serial-interface port
`timescale 1ns/1ps
`default_nettype none

module gpio_port_data #(
	parameter int DATA_W = gpio_port_pkg::DATA_W
) (
	input  wire logic                      clk,
	input  wire logic                      sys_rst,
	input  wire logic [31:0]               bus_addr,
	input  wire logic                      bus_wr,
	input  wire logic                      bus_rd,
	input  wire logic [7:0]                bus_wdata,
	output var  logic [7:0]                bus_rdata,
	output var  logic                      bus_rd_ack,
	input  wire logic [7:0]                port_j_pin_in,
	input  wire logic [7:0]                port_j_mode_hi,
	input  wire logic [7:0]                port_j_mode_lo,
	output var  logic [7:0]                port_j_pin_out,
	output var  logic [7:0]                port_j_pin_oe_n,
	input  wire logic [7:0]                port_k_pin_in,
	input  wire logic [7:0]                port_k_mode_hi,
	input  wire logic [7:0]                port_k_mode_lo,
	output var  logic [7:0]                port_k_pin_out,
	output var  logic [7:0]                port_k_pin_oe_n,
	input  wire logic [7:0]                port_l_pin_in,
	input  wire logic [7:0]                port_l_mode_hi,
	input  wire logic [7:0]                port_l_mode_lo,
	input  wire logic [7:0]                serial_port_pin_in,
	input  wire logic [7:0]                serial_port_mode_hi,
	input  wire logic [7:0]                serial_port_mode_lo,
	output var  logic [6:0]                serial_port_pin_out,
	output var  logic [6:0]                serial_port_pin_oe_n,
	input  wire logic                      receive_enable_bit
);

	// ------------------------------------------------------------------
	// elaboration checks
	// ------------------------------------------------------------------
	// registers are single bytes on the processor bus
	if (DATA_W != 8) begin : g_bad_width
		$error("gpio_port_data serves only eight-bit data");
	end

	// ------------------------------------------------------------------
	// mode decoding
	// ------------------------------------------------------------------
	// either input code, pull-up on or off
	function automatic logic is_input(input logic hi, input logic lo);
		gpio_port_pkg::pin_mode_t m;
		m = gpio_port_pkg::pin_mode_t'({hi, lo});
		return (m == gpio_port_pkg::MODE_IN_PULLUP) || (m == gpio_port_pkg::MODE_IN_NOPULL);
	endfunction

	function automatic logic is_output(input logic hi, input logic lo);
		return gpio_port_pkg::pin_mode_t'({hi, lo}) == gpio_port_pkg::MODE_OUTPUT;
	endfunction

	// ------------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------------
	logic hit_j;
	logic hit_k;
	logic hit_l;
	logic hit_scp;

	assign hit_j   = bus_addr == gpio_port_pkg::PORT_J_DATA_ADDR;
	assign hit_k   = bus_addr == gpio_port_pkg::PORT_K_DATA_ADDR;
	assign hit_l   = bus_addr == gpio_port_pkg::PORT_L_INPUT_DATA_ADDR;
	assign hit_scp = bus_addr == gpio_port_pkg::SERIAL_PORT_PIN_DATA_ADDR;

	// ------------------------------------------------------------------
	// stored data bits
	// ------------------------------------------------------------------
	logic [7:0] port_j_data;
	logic [7:0] port_k_data;
	logic [6:0] serial_port_pin_data;

	// only sys_rst (power-on) clears; no other reset source reaches here
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			port_j_data <= gpio_port_pkg::PORT_J_DATA_RST;
		end else if (bus_wr && hit_j) begin
			port_j_data <= bus_wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			port_k_data <= gpio_port_pkg::PORT_K_DATA_RST;
		end else if (bus_wr && hit_k) begin
			port_k_data <= bus_wdata;
		end
	end

	// bit 7 has no storage, so a write to it is dropped
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			serial_port_pin_data <= gpio_port_pkg::SERIAL_PORT_DATA_RST;
		end else if (bus_wr && hit_scp) begin
			serial_port_pin_data <= bus_wdata[6:0];
		end
	end

	assign port_j_pin_out      = port_j_data;
	assign port_k_pin_out      = port_k_data;
	assign serial_port_pin_out = serial_port_pin_data;

	// ------------------------------------------------------------------
	// per-bit read values and pin drive
	// ------------------------------------------------------------------
	logic [7:0] j_read;
	logic [7:0] k_read;
	logic [7:0] l_read;
	logic [7:0] scp_read;
	logic [7:0] j_drive;
	logic [7:0] k_drive;
	logic [6:0] scp_drive;
	logic [6:0] scp_rx;

	assign scp_rx = receive_enable_bit ? gpio_port_pkg::SCP_RX_MASK : 7'h00;

	for (genvar n = 0; n < 8; n++) begin : g_bit
		// input modes read the pin, the others the stored bit
		assign j_read[n] = is_input(port_j_mode_hi[n], port_j_mode_lo[n]) ?
			port_j_pin_in[n] : port_j_data[n];
		assign k_read[n] = is_input(port_k_mode_hi[n], port_k_mode_lo[n]) ?
			port_k_pin_in[n] : port_k_data[n];
		// input-only port: no storage, zero outside input modes
		assign l_read[n] = is_input(port_l_mode_hi[n], port_l_mode_lo[n]) &
			port_l_pin_in[n];
		assign j_drive[n] = is_output(port_j_mode_hi[n], port_j_mode_lo[n]);
		assign k_drive[n] = is_output(port_k_mode_hi[n], port_k_mode_lo[n]);
	end

	for (genvar n = 0; n < 7; n++) begin : g_scp
		// enabled receiver lines read the pin whatever the mode
		assign scp_read[n] = (is_input(serial_port_mode_hi[n], serial_port_mode_lo[n]) |
			scp_rx[n]) ? serial_port_pin_in[n] : serial_port_pin_data[n];
		assign scp_drive[n] = is_output(serial_port_mode_hi[n], serial_port_mode_lo[n]) &
			~scp_rx[n];
	end

	// input-only serial bit reads low outside input modes
	assign scp_read[7] = is_input(serial_port_mode_hi[7], serial_port_mode_lo[7]) &
		serial_port_pin_in[7];

	// ------------------------------------------------------------------
	// pin output enables, low while driving
	// ------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			port_j_pin_oe_n <= gpio_port_pkg::PIN_OE_N_RST;
			port_k_pin_oe_n <= gpio_port_pkg::PIN_OE_N_RST;
			serial_port_pin_oe_n <= gpio_port_pkg::SCP_OE_N_RST;
		end else begin
			port_j_pin_oe_n <= ~j_drive;
			port_k_pin_oe_n <= ~k_drive;
			serial_port_pin_oe_n <= ~scp_drive;
		end
	end

	// ------------------------------------------------------------------
	// read data path
	// ------------------------------------------------------------------
	logic [7:0] next_rdata;

	// read select; unmapped addresses answer zero
	always_comb begin
		next_rdata = gpio_port_pkg::UNMAPPED_READ;
		if (hit_j) begin
			next_rdata = j_read;
		end else if (hit_k) begin
			next_rdata = k_read;
		end else if (hit_l) begin
			next_rdata = l_read;
		end else if (hit_scp) begin
			next_rdata = scp_read;
		end
	end

	// read data holds until the next read
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			bus_rdata <= gpio_port_pkg::UNMAPPED_READ;
		end else if (bus_rd) begin
			bus_rdata <= next_rdata;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			bus_rd_ack <= 1'b0;
		end else begin
			bus_rd_ack <= bus_rd;
		end
	end

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	property p_reset_clears;
		disable iff (1'b0)
		sys_rst |=> port_j_pin_out == 8'h00 && port_k_pin_out == 8'h00 &&
			serial_port_pin_out == 7'h00 && port_j_pin_oe_n == 8'hFF;
	endproperty
	a_reset_clears: assert property (p_reset_clears) else $error("reset values wrong");

	property p_j_write_stores;
		bus_wr && hit_j |=> port_j_pin_out == $past(bus_wdata);
	endproperty
	a_j_write_stores: assert property (p_j_write_stores) else $error("port j write lost");

	property p_j_hold;
		!(bus_wr && hit_j) |=> $stable(port_j_pin_out);
	endproperty
	a_j_hold: assert property (p_j_hold) else $error("port j changed without write");

	property p_k_output_readback;
		bus_rd && hit_k && !bus_wr && port_k_mode_hi == 8'h00 |=>
			bus_rdata == port_k_pin_out && bus_rd_ack;
	endproperty
	a_k_output_readback: assert property (p_k_output_readback)
		else $error("port k read did not return stored bits");

	property p_k_input_no_drive;
		port_k_mode_hi == 8'hFF |=> port_k_pin_oe_n == 8'hFF;
	endproperty
	a_k_input_no_drive: assert property (p_k_input_no_drive)
		else $error("port k drives an input pin");

	property p_l_read;
		bus_rd && hit_l |=> bus_rdata == ($past(port_l_pin_in) & $past(port_l_mode_hi));
	endproperty
	a_l_read: assert property (p_l_read) else $error("port l read value wrong");

	property p_scp_bit7_low;
		bus_rd && hit_scp && !serial_port_mode_hi[7] |=> !bus_rdata[7];
	endproperty
	a_scp_bit7_low: assert property (p_scp_bit7_low) else $error("serial bit 7 not low");

	property p_scp_write;
		bus_wr && hit_scp |=> serial_port_pin_out == $past(bus_wdata[6:0]);
	endproperty
	a_scp_write: assert property (p_scp_write) else $error("serial port write lost");

	property p_rx_inputs;
		receive_enable_bit |=> (serial_port_pin_oe_n & gpio_port_pkg::SCP_RX_MASK) ==
			gpio_port_pkg::SCP_RX_MASK;
	endproperty
	a_rx_inputs: assert property (p_rx_inputs) else $error("rx pin driven while enabled");

	property p_rx_read;
		bus_rd && hit_scp && receive_enable_bit |=>
			bus_rdata[4] == $past(serial_port_pin_in[4]) &&
			bus_rdata[0] == $past(serial_port_pin_in[0]);
	endproperty
	a_rx_read: assert property (p_rx_read) else $error("rx pin level not read");

	property p_k_hold;
		!(bus_wr && hit_k) |=> $stable(port_k_pin_out);
	endproperty
	a_k_hold: assert property (p_k_hold)
		else $error("port k changed without write");

	property p_scp_hold;
		!(bus_wr && hit_scp) |=> $stable(serial_port_pin_out);
	endproperty
	a_scp_hold: assert property (p_scp_hold)
		else $error("serial port changed without write");

	property p_j_output_drive;
		port_j_mode_hi == 8'h00 && port_j_mode_lo == 8'hFF |=> port_j_pin_oe_n == 8'h00;
	endproperty
	a_j_output_drive: assert property (p_j_output_drive)
		else $error("port j output pin not driven");

	property p_scp_bit7_pin;
		bus_rd && hit_scp && serial_port_mode_hi[7] |=>
			bus_rdata[7] == $past(serial_port_pin_in[7]);
	endproperty
	a_scp_bit7_pin: assert property (p_scp_bit7_pin)
		else $error("serial bit 7 pin level not read");

	property p_rd_ack;
		bus_rd |=> bus_rd_ack;
	endproperty
	a_rd_ack: assert property (p_rd_ack)
		else $error("read not acknowledged");

	// write then read of port j, with or without an idle cycle between
	c_j_write: cover property (bus_wr && hit_j ##[1:2] bus_rd && hit_j);
	c_l_read: cover property (bus_rd && hit_l && port_l_mode_hi != 8'h00);
	c_rx_read: cover property (bus_rd && hit_scp && receive_enable_bit);

endmodule

`default_nettype wire

// File: rtl/gpio_port_pkg.sv
// constants shared by the general-purpose port data register block
package gpio_port_pkg;

	// ------------------------------------------------------------------
	// bus geometry
	// ------------------------------------------------------------------
	localparam int          ADDR_W = 32;
	localparam int          DATA_W = 8;
	localparam int          SCP_RW_W = 7;   // writable bits of the serial port register
	localparam int          SCP_IN_BIT = 7; // input-only bit of the serial port register

	// ------------------------------------------------------------------
	// register byte addresses
	// ------------------------------------------------------------------
	localparam logic [31:0] PORT_J_DATA_ADDR = 32'h0400_0130;
	localparam logic [31:0] PORT_K_DATA_ADDR = 32'h0400_0132;
	localparam logic [31:0] PORT_L_INPUT_DATA_ADDR = 32'h0400_0134;
	localparam logic [31:0] SERIAL_PORT_PIN_DATA_ADDR = 32'h0400_0136;

	// ------------------------------------------------------------------
	// values after power-on reset
	// ------------------------------------------------------------------
	localparam logic [7:0]  PORT_J_DATA_RST = 8'h00;
	localparam logic [7:0]  PORT_K_DATA_RST = 8'h00;
	localparam logic [6:0]  SERIAL_PORT_DATA_RST = 7'h00;
	localparam logic [7:0]  UNMAPPED_READ = 8'h00;
	localparam logic [7:0]  PIN_OE_N_RST = 8'hFF;   // nothing driven after reset
	localparam logic [6:0]  SCP_OE_N_RST = 7'h7F;

	// receive-data pins of the three serial channels (bits 4, 2, 0)
	localparam logic [6:0]  SCP_RX_MASK = 7'h15;

	// ------------------------------------------------------------------
	// per-pin mode codes from the pin function controller
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_OTHER     = 2'b00,
		MODE_OUTPUT    = 2'b01,  // reserved on input-only pins
		MODE_IN_PULLUP = 2'b10,
		MODE_IN_NOPULL = 2'b11
	} pin_mode_t;

endpackage

// File: bench/board_pins.sv
// board-side model of a group of port pins
`timescale 1ns/1ps
`default_nettype none

module board_pins #(
	parameter int W = 8
) (
	input  wire logic [W-1:0] pin_out,
	input  wire logic [W-1:0] pin_oe_n,
	input  wire logic [W-1:0] ext,
	output var  logic [W-1:0] pin
);
	// block level where it drives, board level everywhere else
	always_comb begin
		for (int i = 0; i < W; i++) begin
			pin[i] = pin_oe_n[i] ? ext[i] : pin_out[i];
		end
	end
endmodule

`default_nettype wire

// File: bench/tb.sv
// self-checking bench for the port data register block
`timescale 1ns/1ps
`default_nettype none

module tb;
	localparam logic [31:0] AJ = gpio_port_pkg::PORT_J_DATA_ADDR;
	localparam logic [31:0] AK = gpio_port_pkg::PORT_K_DATA_ADDR;
	localparam logic [31:0] AL = gpio_port_pkg::PORT_L_INPUT_DATA_ADDR;
	localparam logic [31:0] AS = gpio_port_pkg::SERIAL_PORT_PIN_DATA_ADDR;
	logic        clk, sys_rst, bus_wr, bus_rd, bus_rd_ack, rx_en;
	logic [31:0] bus_addr;
	logic [7:0]  bus_wdata, bus_rdata, j_hi, j_lo, j_ext, j_pin, j_out, j_oen;
	logic [7:0]  k_hi, k_lo, k_ext, k_pin, k_out, k_oen, l_hi, l_lo, l_pin;
	logic [7:0]  s_hi, s_lo, s_ext, ws;
	logic [6:0]  s_pin, s_out, s_oen;
	int          num_errors, check_count;

	// --------------------------------------------------------------
	// design and board
	// --------------------------------------------------------------
	gpio_port_data gpio_port_data_inst (
		.clk(clk), .sys_rst(sys_rst), .bus_addr(bus_addr), .bus_wr(bus_wr),
		.bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
		.bus_rd_ack(bus_rd_ack), .port_j_pin_in(j_pin), .port_j_mode_hi(j_hi),
		.port_j_mode_lo(j_lo), .port_j_pin_out(j_out), .port_j_pin_oe_n(j_oen),
		.port_k_pin_in(k_pin), .port_k_mode_hi(k_hi), .port_k_mode_lo(k_lo),
		.port_k_pin_out(k_out), .port_k_pin_oe_n(k_oen), .port_l_pin_in(l_pin),
		.port_l_mode_hi(l_hi), .port_l_mode_lo(l_lo),
		.serial_port_pin_in({s_ext[7], s_pin}), .serial_port_mode_hi(s_hi),
		.serial_port_mode_lo(s_lo), .serial_port_pin_out(s_out),
		.serial_port_pin_oe_n(s_oen), .receive_enable_bit(rx_en)
	);
	board_pins #(.W(8)) board_j_inst (.pin_out(j_out), .pin_oe_n(j_oen), .ext(j_ext), .pin(j_pin));
	board_pins #(.W(8)) board_k_inst (.pin_out(k_out), .pin_oe_n(k_oen), .ext(k_ext), .pin(k_pin));
	board_pins #(.W(7)) board_s_inst (.pin_out(s_out), .pin_oe_n(s_oen), .ext(s_ext[6:0]),
		.pin(s_pin));

	// clock at 40 MHz
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// --------------------------------------------------------------
	// tasks
	// --------------------------------------------------------------
	task automatic give_verdict();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", name, exp, got);
			num_errors++;
		end
	endtask

	// one-cycle write strobe
	task automatic wr(input logic [31:0] a, input logic [7:0] d);
		@(negedge clk);
		bus_addr = a;
		bus_wdata = d;
		bus_wr = 1'b1;
		@(negedge clk);
		bus_wr = 1'b0;
	endtask

	// one-cycle read strobe, bounded wait for the acknowledge
	task automatic rd(input logic [31:0] a, input logic [7:0] exp, input string name);
		int i;
		@(negedge clk);
		bus_addr = a;
		bus_rd = 1'b1;
		for (i = 0; i < 4; i++) begin
			@(negedge clk);
			bus_rd = 1'b0;
			if (bus_rd_ack === 1'b1) break;
		end
		if (i == 4) begin
			$display("Error %s ack expected 1 seen 0", name);
			num_errors++;
		end else begin
			check(name, exp, bus_rdata);
		end
	endtask

	// same mode code on every pin of every port
	task automatic set_modes(input logic [1:0] m);
		j_hi = {8{m[1]}};
		j_lo = {8{m[0]}};
		k_hi = {8{m[1]}};
		k_lo = {8{m[0]}};
		l_hi = {8{m[1]}};
		l_lo = {8{m[0]}};
		s_hi = {8{m[1]}};
		s_lo = {8{m[0]}};
	endtask

	// --------------------------------------------------------------
	// main sequence
	// --------------------------------------------------------------
	initial begin
		num_errors = 0;
		check_count = 0;
		{bus_wr, bus_rd, rx_en} = 3'h0;
		bus_addr = 32'h0000_0000;
		bus_wdata = 8'h00;
		set_modes(2'h0);
		s_hi = 8'hFF;
		j_ext = 8'hC3;
		k_ext = 8'h5A;
		l_pin = 8'h96;
		s_ext = 8'hA5;
		sys_rst = 1'b1;
		repeat (20) @(negedge clk);
		sys_rst = 1'b0;
		// values after power-on reset
		rd(AJ, 8'h00, "port j reset");
		rd(AK, 8'h00, "port k reset");
		rd(AL, 8'h00, "port l reset");
		rd(AS, 8'hA5, "serial reset");
		check("port j drive reset", 8'hFF, j_oen);
		// every mode code on every port
		for (int m = 0; m < 4; m++) begin
			set_modes(2'(m));
			ws = 8'hD5 ^ 8'(m);
			wr(AJ, 8'h30 + 8'(m));
			wr(AK, ws);
			wr(AL, 8'hFF);
			wr(AS, ws);
			rd(AJ, m[1] ? j_ext : 8'h30 + 8'(m), "port j");
			rd(AK, m[1] ? k_ext : ws, "port k");
			rd(AL, m[1] ? l_pin : 8'h00, "port l");
			rd(AS, m[1] ? s_ext : {1'b0, ws[6:0]}, "serial");
			check("port j drive", (m == 1) ? 8'h00 : 8'hFF, j_oen);
			check("port k level", ws, k_out);
			check("port j level", 8'h30 + 8'(m), j_out);
			check("port k drive", (m == 1) ? 8'h00 : 8'hFF, k_oen);
			check("serial drive", {1'b0, (m == 1) ? 7'h00 : 7'h7F}, {1'b0, s_oen});
			check("serial level", {1'b0, ws[6:0]}, {1'b0, s_out});
		end
		// stored bits survive mode changes; unmapped place
		set_modes(2'h0);
		rd(AJ, 8'h33, "port j kept");
		rd(32'h0400_0138, 8'h00, "unmapped read");
		wr(32'h0400_0138, 8'hFF);
		rd(AS, 8'h56, "serial kept");
		// receive enable turns rx pins into inputs
		set_modes(2'h1);
		rx_en = 1'b1;
		wr(AS, 8'h6B);
		rd(AS, {1'b0, (7'h6B & ~7'h15) | (s_ext[6:0] & 7'h15)}, "serial rx");
		check("serial rx drive", 8'h15, {1'b0, s_oen});
		rx_en = 1'b0;
		// mixed modes within one port
		j_hi = 8'hF0;
		j_lo = 8'h0F;
		wr(AJ, 8'h96);
		rd(AJ, {j_ext[7:4], 4'h6}, "port j mixed");
		check("port j mixed drive", 8'hF0, j_oen);
		// second power-on reset
		sys_rst = 1'b1;
		repeat (2) @(negedge clk);
		sys_rst = 1'b0;
		set_modes(2'h0);
		rd(AJ, 8'h00, "port j reset again");
		rd(AK, 8'h00, "port k reset again");
		rd(AS, 8'h00, "serial reset again");
		give_verdict();
	end
endmodule

`default_nettype wire
